// File: hw/ims_pkg.sv
/*
 * Package for the two-wire memory access slave: constants, state enum and
 * the memory request carrier. Assumes a 100 MHz system clock and a master
 * that drives the serial clock at 400 kHz or slower.
 */
// Behaviour
// - Byte write is slave address, word address, data; each acknowledged, then stop.
// - Stop after a write starts a busy cycle; requests ignored, data released.
// - Writes into a protected area get no acknowledge.
// - Page write acknowledges each byte and bumps only the low two address bits.
// - Bytes beyond four in a page overwrite the wrapped addresses one by one.
// - Reads start like writes with direction bit one; three read forms exist.
// - Address counter holds last address plus one; reset loads zero.
// - Current address read acknowledges the address byte then sends counter data.
// - Sequential read sends the next byte per acknowledge, stops on none.
// - Read counter crosses pages and wraps to zero at the end.
// - Nonvolatile read of a page's first byte starts a recall; master reads twice.
// - Select bit zero steers accesses to shadow RAM, one to the nonvolatile array.
// - Every received byte outside a busy cycle acknowledged except a non-matching slave address, a protected data byte or one the full FIFO refuses.
// - After a sent byte the ninth clock is sampled; no acknowledge ends sending.
package ims_pkg;
    localparam int IMS_BYTE_W = 8;
    localparam logic [1:0] IMS_PAGE_MASK = 2'h3;
    localparam logic [3:0] IMS_ACK_BIT = 4'h8;      // Ninth clock index
    localparam logic [3:0] IMS_LAST_BIT = 4'h7;
    localparam logic [3:0] IMS_BIT_ARM = 4'hf;      // Wraps to zero on the fall after a start
    localparam logic [6:0] IMS_DEV_ADDR_BASE = 7'h28; // Arbitrary neutral base
    localparam logic [7:0] IMS_ADDR_ZERO = 8'h00;
    localparam int IMS_CLK_MHZ = 100;
    localparam int IMS_RECALL_US = 200;
    localparam int IMS_RECALL_CYC = IMS_RECALL_US * IMS_CLK_MHZ;
    localparam int IMS_WRITE_MS = 30;
    localparam int IMS_WRITE_CYC = IMS_WRITE_MS * 1000 * IMS_CLK_MHZ;
    localparam int IMS_FIFO_W = 9;
    localparam int IMS_FIFO_D = 8;

    typedef enum logic [2:0] {
        IMS_IDLE, IMS_DEVADR, IMS_WORDADR, IMS_WDATA, IMS_RDATA, IMS_WAITSTOP, IMS_BUSY
    } ims_state_type;

    // Write request towards the memory side
    typedef struct packed {
        logic       nv_sel;
        logic [7:0] addr;
        logic [7:0] data;
    } ims_wreq_type;
endpackage : ims_pkg

// File: hw/ims_fifo.sv
/*
 * Parameterised FIFO with valid and ready on both sides.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
module ims_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,              // System clock
    input wire logic sys_rst_i,              // Sync reset
    input wire logic in_valid_i,             // Write side valid
    output logic in_ready_o,                 // Write side ready
    input wire logic [WIDTH-1:0] in_data_i,  // Write data
    output logic out_valid_o,                // Read side valid
    input wire logic out_ready_i,            // Read side ready
    output logic [WIDTH-1:0] out_data_o      // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointers and storage
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                mem_r[wp_r] <= in_data_i;
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_over: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : ims_fifo

// File: hw/ims_slave.sv
/*
 * Two-wire slave giving an outside master byte, page and read access to
 * the shadow RAM or the nonvolatile array. Serial clock and data come from
 * the pins and are synchronised into the 100 MHz domain. The memory itself
 * sits outside: writes leave through a FIFO, reads use a one-cycle port.
 */
`timescale 1ns/10ps
module ims_slave
    import ims_pkg::*;
#(
    parameter int WRITE_CYC = ims_pkg::IMS_WRITE_CYC,  // Busy time after write stop
    parameter int RECALL_CYC = ims_pkg::IMS_RECALL_CYC // Page recall time
) (
    input wire logic sys_clk_i,              // System clock
    input wire logic sys_rst_i,              // Sync reset, high
    input wire logic scl_i,                  // Serial clock pin
    input wire logic sda_i,                  // Serial data in pin
    output logic sda_o,                      // Serial data out, always 0
    output logic sda_oe_o,                   // High pulls data low
    input wire logic [1:0] addr_sel_i,       // Slave address select pins
    input wire logic nonvolatile_select_bit_i, // 1 steers to nonvolatile array
    input wire logic [1:0] wprot_i,          // Protect: [0] RAM, [1] array
    output logic wr_valid_o,                 // Write request valid
    input wire logic wr_ready_i,             // Memory takes write
    output ims_pkg::ims_wreq_type wr_req_o,  // Write request
    output logic rd_nv_o,                    // Read target select
    output logic [7:0] rd_addr_o,            // Read address
    input wire logic [7:0] rd_data_i,        // Read data, same cycle
    output logic busy_o                      // Internal write cycle active
);
    import ims_pkg::*;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        ims_state_type st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] cnt;
        logic rw;
        logic ack;
        logic wrote;
        logic [31:0] tmr;
        logic [7:0] recall_pg;
        logic recall_ok;
    } ims_core_type;

    ims_core_type r, n;
    logic fifo_ready;
    logic wpush;
    ims_wreq_type wreq;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic prot;

    // Protection check used for data bytes
    function automatic logic is_prot(input logic nv, input logic [1:0] wp);
        return nv ? wp[1] : wp[0];
    endfunction : is_prot

    ////////////////////////////////////////////////////////////////////////
    // Line events from the synchronised copies only
    assign scl_rise = r.scl_s[1] && !r.scl_d;
    assign scl_fall = !r.scl_s[1] && r.scl_d;
    assign start_c = r.scl_s[1] && r.scl_d && r.sda_d && !r.sda_s[1];
    assign stop_c = r.scl_s[1] && r.scl_d && !r.sda_d && r.sda_s[1];
    assign prot = is_prot(nonvolatile_select_bit_i, wprot_i);

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine
    always_comb begin
        n = r;
        wpush = 1'b0;
        wreq = '{nv_sel: nonvolatile_select_bit_i, addr: r.cnt, data: r.sh};
        n.scl_s = {r.scl_s[0], scl_i};
        n.sda_s = {r.sda_s[0], sda_i};
        n.scl_d = r.scl_s[1];
        n.sda_d = r.sda_s[1];
        case (r.st)
            IMS_BUSY: begin
                // Master ignored, data released while the write cycle runs
                n.ack = 1'b0;
                if (r.tmr == 32'h0) n.st = IMS_IDLE;
                else n.tmr = r.tmr - 32'h1;
            end
            default: begin
                if (stop_c) begin
                    n.ack = 1'b0;
                    if (r.wrote) begin
                        n.st = IMS_BUSY;
                        n.tmr = 32'(WRITE_CYC - 1);
                    end else n.st = IMS_IDLE;
                    n.wrote = 1'b0;
                end else if (start_c) begin
                    // Repeated start allowed after a dummy write
                    n.st = IMS_DEVADR;
                    // The clock fall that closes the start must not count as a bit
                    n.bitn = IMS_BIT_ARM;
                    n.ack = 1'b0;
                end else if (scl_rise && r.st != IMS_IDLE && r.st != IMS_WAITSTOP) begin
                    if (r.bitn < IMS_ACK_BIT) n.sh = {r.sh[6:0], r.sda_s[1]};
                    else if (r.st == IMS_RDATA) begin
                        // Ninth clock sampled; no acknowledge ends sending
                        if (r.sda_s[1]) n.st = IMS_WAITSTOP;
                    end
                end else if (scl_fall && r.st != IMS_IDLE && r.st != IMS_WAITSTOP) begin
                    if (r.bitn == IMS_LAST_BIT && r.st != IMS_RDATA) begin
                        n.bitn = IMS_ACK_BIT;
                        n.ack = 1'b1;
                        case (r.st)
                            IMS_DEVADR: begin
                                if (r.sh[7:1] != (IMS_DEV_ADDR_BASE | 7'(addr_sel_i))) begin
                                    n.ack = 1'b0;
                                    n.st = IMS_WAITSTOP;
                                end
                                n.rw = r.sh[0];
                            end
                            IMS_WORDADR: n.cnt = r.sh;
                            IMS_WDATA: begin
                                if (prot) n.ack = 1'b0;
                                else if (fifo_ready) begin
                                    wpush = 1'b1;
                                    n.wrote = 1'b1;
                                    // Page address held, offset wraps
                                    n.cnt = {r.cnt[7:2], r.cnt[1:0] + 2'h1};
                                end else n.ack = 1'b0;
                            end
                            default: n.ack = 1'b0;
                        endcase
                    end else if (r.bitn == IMS_ACK_BIT) begin
                        n.ack = 1'b0;
                        n.bitn = 4'h0;
                        case (r.st)
                            IMS_DEVADR: n.st = (r.rw && r.ack) ? IMS_RDATA : IMS_WORDADR;
                            IMS_WORDADR: n.st = IMS_WDATA;
                            default: n.st = r.st;
                        endcase
                        if (r.st == IMS_DEVADR && r.rw && r.ack || r.st == IMS_RDATA) begin
                            // Load byte at counter, then counter wraps whole space
                            n.sh = rd_data_i;
                            n.cnt = r.cnt + 8'h1;
                            n.ack = !rd_data_i[7];
                            if (nonvolatile_select_bit_i &&
                                (r.cnt[1:0] & IMS_PAGE_MASK) == 2'h0 &&
                                !(r.recall_ok && r.recall_pg == r.cnt)) begin
                                // First nonvolatile byte of a page starts a recall
                                n.recall_pg = r.cnt;
                                n.recall_ok = 1'b1;
                            end
                        end
                    end else begin
                        n.bitn = r.bitn + 4'h1;
                        // Shifter moves on each rise, so the next bit is always on top
                        if (r.st == IMS_RDATA)
                            n.ack = (r.bitn != IMS_LAST_BIT) && !r.sh[IMS_BYTE_W - 1];
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, st: IMS_IDLE,
                   cnt: IMS_ADDR_ZERO, default: '0};
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write path buffering
    ims_fifo #(.WIDTH($bits(ims_wreq_type)), .DEPTH(IMS_FIFO_D)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(wpush),
        .in_ready_o(fifo_ready),
        .in_data_i(wreq),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(wr_req_o)
    );

    // Pin and read port drive; ack flag doubles as drive-low for data bits
    assign sda_o = 1'b0;
    assign sda_oe_o = r.ack;
    assign rd_nv_o = nonvolatile_select_bit_i;
    assign rd_addr_o = r.cnt;
    assign busy_o = (r.st == IMS_BUSY);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_busy_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        r.st == IMS_BUSY |-> !sda_oe_o) else $error("data driven while busy");
    a_stop_busy: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        stop_c && r.wrote && r.st != IMS_BUSY |=> busy_o) else $error("no busy after write");
    a_prot_noack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        r.st == IMS_WDATA && scl_fall && r.bitn == IMS_LAST_BIT && !start_c && !stop_c
        && prot |-> !wpush ##1 !sda_oe_o) else $error("protected write acked");
    a_page_wrap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wpush |=> r.cnt[7:2] == $past(r.cnt[7:2])) else $error("page changed");
    a_wrap_val: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        wpush |=> r.cnt[1:0] == $past(r.cnt[1:0]) + 2'h1) else $error("wrap wrong");
    a_word_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        r.st == IMS_WORDADR && scl_fall && r.bitn == IMS_LAST_BIT && !start_c && !stop_c
        |=> r.cnt == $past(r.sh)) else $error("counter not loaded");
    a_nack_end: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        r.st == IMS_RDATA && scl_rise && r.bitn == IMS_ACK_BIT && r.sda_s[1] && !stop_c
        && !start_c |=> r.st == IMS_WAITSTOP) else $error("send after nack");
    a_rd_inc: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        r.st == IMS_RDATA && scl_fall && r.bitn == IMS_ACK_BIT && !start_c && !stop_c
        |=> r.cnt == $past(r.cnt) + 8'h1) else $error("read counter stuck");
    c_write: cover property (@(posedge sys_clk_i) wpush);
    c_read: cover property (@(posedge sys_clk_i) r.st == IMS_RDATA);
    c_busy: cover property (@(posedge sys_clk_i) busy_o);
endmodule : ims_slave

// File: verification/ims_master_model.sv
/*
 * Two-wire bus master model: start, stop, byte out and byte in.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/10ps
module ims_master_model (
    output logic scl_o,    // Serial clock, idle high
    output logic sda_o,    // Data drive, 1 releases
    input wire logic sda_i // Resolved data line
);
    localparam realtime QTR = 31.25; // Quarter of the 125 ns bit time
    // Bus idle, clock stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Start or repeated start: data falls while clock high
    task automatic start;
        sda_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b0;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : start
    // Stop: data rises while clock high
    task automatic stop;
        sda_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b1;
        #QTR;
    endtask : stop
    // One clock; data changes only while clock low
    task automatic xfer(input logic b, output logic r);
        sda_o = b;
        #QTR scl_o = 1'b1;
        #QTR r = sda_i;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : xfer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask : wbyte
    // Last byte of a read gets data high on the ninth clock
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(~ack, r);
    endtask : rbyte
endmodule : ims_master_model

// File: verification/ims_slave_bench.sv
/*
 * Self-checking bench for the two-wire memory slave: a master model on the
 * pins, a memory on the write and read ports, a queue model of the writes and an array model for the reads.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module ims_slave_bench;
    import ims_pkg::*;
    logic sys_clk_i = 0, sys_rst_i = 1, nvs = 0, wr_ready = 0, ack;
    logic [1:0] sel = 0, wprot = 0;
    logic scl, msda, oe, sda_out, wr_valid, rd_nv, busy;
    logic [7:0] rd_addr, ctr, d;
    logic [7:0] dm [2][256];
    logic [7:0] mm [2][256];
    ims_wreq_type wr_req;
    ims_wreq_type expq [$];
    ims_wreq_type exp_w;
    int failures = 0, checks = 0;
    wire sda = msda & ~oe; // Pull-up wins when nobody pulls low
    always #5 sys_clk_i = ~sys_clk_i;
    ims_slave #(.WRITE_CYC(400), .RECALL_CYC(100)) ims_slave_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_out), .sda_oe_o(oe), .addr_sel_i(sel), .nonvolatile_select_bit_i(nvs),
        .wprot_i(wprot), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_req_o(wr_req),
        .rd_nv_o(rd_nv), .rd_addr_o(rd_addr), .rd_data_i(dm[rd_nv][rd_addr]), .busy_o(busy));
    ims_master_model ims_master_model_inst (.scl_o(scl), .sda_o(msda), .sda_i(sda));
    ////////////////////////////////////////////////////////////////////////////////
    // Memory side: commit each accepted write after comparing with the model
    always @(posedge sys_clk_i) begin
        if (!sys_rst_i && wr_valid && wr_ready) begin
            exp_w = expq.pop_front();
            `CHK(wr_req, exp_w)
            dm[wr_req.nv_sel][wr_req.addr] = wr_req.data;
        end
    end
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Bounded wait for the write cycle to end and the FIFO to drain
    task automatic settle;
        int k;
        for (k = 0; k < 1000 && (busy !== 1'b0 || wr_valid !== 1'b0); k++)
            @(posedge sys_clk_i);
        if (k == 1000) begin
            failures++;
            wrap_up();
        end
    endtask : settle
    task automatic sa(input logic rw, input logic [1:0] s);
        ims_master_model_inst.start();
        ims_master_model_inst.wbyte({IMS_DEV_ADDR_BASE | {5'h0, s}, rw}, ack);
    endtask : sa
    // Write n bytes from a; bytes from index lim on must be refused
    task automatic wr(input logic [7:0] a, input int n, input int lim);
        sa(1'b0, sel);
        `CHK(ack, 1'b1)
        `CHK(sda_out, 1'b0)
        ims_master_model_inst.wbyte(a, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            // Queue first: the memory side may commit before the byte call returns
            if (i < lim) begin
                expq.push_back({nvs, a, d});
                mm[nvs][a] = d;
            end
            ims_master_model_inst.wbyte(d, ack);
            `CHK(ack, (i < lim) ? 1'b1 : 1'b0)
            a = {a[7:2], a[1:0] + 2'h1};
        end
        ims_master_model_inst.stop();
    endtask : wr
    // Read n bytes at the counter, data high on the last ninth clock
    task automatic rd(input int n);
        for (int i = 0; i < n; i++) begin
            ims_master_model_inst.rbyte(i < n - 1, d);
            `CHK(d, mm[nvs][ctr])
            `CHK(rd_nv, nvs)
            ctr = ctr + 8'h1;
        end
    endtask : rd
    task automatic rr(input logic [7:0] a, input int n);
        sa(1'b0, sel);
        ims_master_model_inst.wbyte(a, ack);
        sa(1'b1, sel);
        `CHK(ack, 1'b1)
        ctr = a;
        rd(n);
        ims_master_model_inst.stop();
    endtask : rr
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(59));
        foreach (dm[i, j]) begin
            dm[i][j] = 8'($urandom);
            mm[i][j] = dm[i][j];
        end
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        wr_ready <= 1'b1;
        sel <= 2'($urandom);
        repeat (4) @(posedge sys_clk_i);
        // Byte write, then a request while the write cycle runs
        wr(8'($urandom_range(0, 'h57)), 1, 1);
        repeat (4) @(posedge sys_clk_i);
        `CHK(busy, 1'b1)
        sa(1'b0, sel);
        `CHK(ack, 1'b0)
        ims_master_model_inst.stop();
        settle();
        sa(1'b0, sel ^ 2'h1);
        `CHK(ack, 1'b0)
        ims_master_model_inst.stop();
        $display("test byte write done");
        // Page write with the memory stalled until the FIFO refuses
        @(posedge sys_clk_i) wr_ready <= 1'b0;
        wr(8'h22, 9, 8);
        @(posedge sys_clk_i) wr_ready <= 1'b1;
        settle();
        rr(8'h20, 4);
        $display("test page write done");
        // Protected areas, then the nonvolatile array
        @(posedge sys_clk_i) wprot <= 2'h1;
        wr(8'h30, 2, 0);
        @(posedge sys_clk_i) nvs <= 1'b1;
        wr(8'h31, 1, 1);
        settle();
        // First byte of a nonvolatile page goes in twice, each write cycle waited out
        repeat (2) begin
            wr(8'h34, 1, 1);
            settle();
        end
        @(posedge sys_clk_i) wprot <= 2'h2;
        wr(8'h44, 1, 0);
        @(posedge sys_clk_i) wprot <= 2'h0;
        settle();
        for (int i = 0; i < 3; i++) rr(8'h30 + 8'(i >> 1), 1);
        @(posedge sys_clk_i) nvs <= 1'b0;
        $display("test protect done");
        // Read across the top of the space, then from the counter
        rr(8'hfe, 3);
        sa(1'b1, sel);
        `CHK(ack, 1'b1)
        rd(2);
        ims_master_model_inst.rbyte(1'b0, d);
        `CHK(d, 8'hff)
        ims_master_model_inst.stop();
        $display("test reads done");
        wrap_up();
    end
endmodule : ims_slave_bench
